// ===== rxs_status_regs.sv
`timescale 1ns/1ps
module rxs_status_regs
  import rxs_pkg::*;
#(
  parameter int CHECK_W = CHECK_W_DEF
)(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Receive path results
  input wire logic pkt_end_in,
  input wire logic check_ok_in,
  input wire logic [LOG_ADDR_W-1:0] log_addr_in,
  input wire logic [CHECK_W-1:0] check_field_in,
  input wire logic [MATCH_W-1:0] match_index_in,
  input wire logic [PAYLOAD_W-1:0] payload_in,
  input wire logic tone_present_in,
  input wire logic [TONE_INFO_W-1:0] tone_info_in,
  // Direction finding machines
  input wire logic [SWITCH_W-1:0] switch_state_in,
  input wire logic sampler_state_in,
  // Interrupt
  output logic irq_out
);
  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  generate
    if (CHECK_W < 1 || CHECK_W > 32)
    begin : g_bad_width
      $error("check field width must be 1 to 32");
    end
  endgenerate

  // ------------------------------------------------------------
  // Packet capture
  // ------------------------------------------------------------
  rxs_cap_if #(.CHECK_W(CHECK_W)) cap ();

  rxs_capture #(
    .CHECK_W(CHECK_W)
  ) u_capture (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .pkt_end_in(pkt_end_in),
    .check_ok_in(check_ok_in),
    .log_addr_in(log_addr_in),
    .check_field_in(check_field_in),
    .match_index_in(match_index_in),
    .payload_in(payload_in),
    .tone_present_in(tone_present_in),
    .tone_info_in(tone_info_in),
    .cap(cap.src)
  );

  // ------------------------------------------------------------
  // Direction finding state sampling
  // ------------------------------------------------------------
  logic [SWITCH_W-1:0] switch_state_reg;
  logic sampler_state_reg;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      switch_state_reg <= SW_IDLE;
      sampler_state_reg <= 1'b0;
    end
    else
    begin
      switch_state_reg <= switch_state_in;
      sampler_state_reg <= sampler_state_in;
    end
  end

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire hit_verdict = (addr_in == OFS_CHECK_VERDICT);
  wire hit_log_addr = (addr_in == OFS_LOGICAL_ADDR);
  wire hit_check = (addr_in == OFS_CHECK_FIELD);
  wire hit_match = (addr_in == OFS_MATCH_INDEX);
  wire hit_payload = (addr_in == OFS_PAYLOAD_STATUS);
  wire hit_tone = (addr_in == OFS_TONE_INFO);
  wire hit_df = (addr_in == OFS_DF_STATE);
  wire hit_status = (addr_in == OFS_INT_STATUS);
  wire hit_mask = (addr_in == OFS_INT_MASK);
  wire status_wr = wr_in & hit_status;
  wire mask_wr = wr_in & hit_mask;
  wire hit_any = hit_verdict | hit_log_addr | hit_check | hit_match | hit_payload
    | hit_tone | hit_df | hit_status | hit_mask;

  // ------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------
  logic [NUM_EV-1:0] int_status;
  logic [NUM_EV-1:0] int_mask;

  rxs_irq u_irq (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .events_in(cap.events),
    .status_wr_in(status_wr),
    .mask_wr_in(mask_wr),
    .wdata_in(wdata_in[NUM_EV-1:0]),
    .status_out(int_status),
    .mask_out(int_mask),
    .irq_out(irq_out)
  );

  // ------------------------------------------------------------
  // Read words
  // ------------------------------------------------------------
  wire [31:0] word_verdict = {31'h0, cap.check_passed};
  wire [31:0] word_log_addr = {{(32-LOG_ADDR_W){1'b0}}, cap.log_addr};
  wire [31:0] word_check = 32'(cap.check_field);
  wire [31:0] word_match = {{(32-MATCH_W){1'b0}}, cap.match_index};
  wire [31:0] word_payload = {{(32-PAYLOAD_W){1'b0}}, cap.payload};
  wire [31:0] word_tone = {24'h0, cap.tone_kind, cap.tone_rsvd, cap.tone_duration};
  wire [31:0] word_df = {28'h0, sampler_state_reg, switch_state_reg};
  wire [31:0] word_status = {{(32-NUM_EV){1'b0}}, int_status};
  wire [31:0] word_mask = {{(32-NUM_EV){1'b0}}, int_mask};

  wire [31:0] rd_word =
    hit_verdict ? word_verdict :
    hit_log_addr ? word_log_addr :
    hit_check ? word_check :
    hit_match ? word_match :
    hit_payload ? word_payload :
    hit_tone ? word_tone :
    hit_df ? word_df :
    hit_status ? word_status :
    hit_mask ? word_mask :
    RESET_WORD;

  // ------------------------------------------------------------
  // Read data, valid only in the cycle after the strobe
  // ------------------------------------------------------------
  logic [31:0] rdata_next;
  assign rdata_next = rd_in ? rd_word : RESET_WORD;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      rdata_out <= RESET_WORD;
    else
      rdata_out <= rdata_next;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_packet_passed;
    pkt_end_in && check_ok_in ##1 rd_in && hit_verdict && !pkt_end_in;
  endsequence

  sequence s_packet_failed;
    pkt_end_in && !check_ok_in ##1 rd_in && hit_verdict && !pkt_end_in;
  endsequence

  sequence s_read_df;
    rd_in && hit_df;
  endsequence

  sequence s_pkt_then_read(logic hit);
    pkt_end_in ##1 rd_in && hit && !pkt_end_in;
  endsequence

  a_verdict_pass_read: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    s_packet_passed |=> rdata_out == 32'h00000001
  ) else $error("passed packet not read back as one");

  a_verdict_fail_read: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    s_packet_failed |=> rdata_out == 32'h00000000
  ) else $error("failed packet not read back as zero");

  a_logical_addr_held: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    pkt_end_in ##1 !pkt_end_in [*3] |-> cap.log_addr == $past(log_addr_in, 3)
  ) else $error("logical address not held after packet");

  a_check_field_copy: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    pkt_end_in ##1 rd_in && hit_check && !pkt_end_in
      |=> rdata_out == 32'($past(check_field_in, 2))
  ) else $error("check field not returned unchanged");

  a_match_index_copy: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    pkt_end_in |=> cap.match_index == $past(match_index_in)
  ) else $error("match index not captured");

  a_tone_fields_split: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    tone_present_in ##1 rd_in && hit_tone && !tone_present_in
      |=> rdata_out[7:0] == $past(tone_info_in, 2) && rdata_out[31:8] == 24'h0
  ) else $error("tone fields not split as received");

  a_df_state_read: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    s_read_df |=> rdata_out[2:0] == $past(switch_state_in, 2)
      && rdata_out[SAMPLER_BIT] == $past(sampler_state_in, 2)
  ) else $error("direction finding state not reported");

  a_irq_from_status: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    1'b1 |-> irq_out == (|(int_status & int_mask))
  ) else $error("interrupt low with unmasked status set");

  a_read_one_cycle: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !rd_in |=> rdata_out == 32'h00000000
  ) else $error("read data stands outside its cycle");

  a_event_sets_status: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    pkt_end_in && !check_ok_in |=> ##1 int_status[EV_FAILED]
  ) else $error("failed check did not set status");

  // ------------------------------------------------------------
  // Capture checks
  // ------------------------------------------------------------
  a_verdict_capture: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    pkt_end_in |=> cap.check_passed == $past(check_ok_in)
  ) else $error("verdict not captured at packet end");

  a_verdict_held: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !pkt_end_in |=> $stable(cap.check_passed)
  ) else $error("verdict changed without a packet");

  a_log_addr_capture: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    pkt_end_in |=> cap.log_addr == $past(log_addr_in)
  ) else $error("logical address not captured");

  a_log_addr_stable: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !pkt_end_in |=> $stable(cap.log_addr)
  ) else $error("logical address changed without a packet");

  a_check_field_capture: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    pkt_end_in |=> cap.check_field == $past(check_field_in)
  ) else $error("check field not captured");

  a_check_field_held: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !pkt_end_in |=> $stable(cap.check_field)
  ) else $error("check field changed without a packet");

  a_match_index_held: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !pkt_end_in |=> $stable(cap.match_index)
  ) else $error("match index changed without a packet");

  a_payload_capture: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    pkt_end_in |=> cap.payload == $past(payload_in)
  ) else $error("payload status not captured");

  a_tone_capture: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    tone_present_in |=> {cap.tone_kind, cap.tone_rsvd, cap.tone_duration} == $past(tone_info_in)
  ) else $error("tone fields not captured");

  a_tone_held: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !tone_present_in |=> $stable({cap.tone_kind, cap.tone_rsvd, cap.tone_duration})
  ) else $error("tone fields changed without a tone pulse");

  a_df_state_capture: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    1'b1 |=> switch_state_reg == $past(switch_state_in)
      && sampler_state_reg == $past(sampler_state_in)
  ) else $error("machine states not sampled");

  // ------------------------------------------------------------
  // Read path checks
  // ------------------------------------------------------------
  a_log_addr_read: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    s_pkt_then_read(hit_log_addr) |=> rdata_out == 32'($past(log_addr_in, 2))
  ) else $error("logical address not read back");

  a_match_index_read: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    s_pkt_then_read(hit_match) |=> rdata_out == 32'($past(match_index_in, 2))
  ) else $error("match index not read back");

  a_payload_read: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    s_pkt_then_read(hit_payload) |=> rdata_out == 32'($past(payload_in, 2))
  ) else $error("payload status not read back");

  a_df_upper_zero: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    s_read_df |=> rdata_out[31:4] == 28'h0
  ) else $error("machine state word has upper bits set");

  a_verdict_upper_zero: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    rd_in && hit_verdict |=> rdata_out[31:1] == 31'h0
  ) else $error("verdict word has upper bits set");

  a_unmapped_read: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    rd_in && !hit_any |=> rdata_out == 32'h00000000
  ) else $error("unmapped read returned nonzero");

  // ------------------------------------------------------------
  // Interrupt checks
  // ------------------------------------------------------------
  a_status_clear: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    status_wr && wdata_in[EV_PASSED] && !cap.events[EV_PASSED] |=> !int_status[EV_PASSED]
  ) else $error("status bit not cleared by write of one");

  a_set_beats_clear: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    cap.events[EV_TONE] |=> int_status[EV_TONE]
  ) else $error("event lost against a clear");

  a_mask_write: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    mask_wr |=> int_mask == $past(wdata_in[NUM_EV-1:0])
  ) else $error("mask not written");

  a_status_sticky: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    int_status[EV_FAILED] && !(status_wr && wdata_in[EV_FAILED]) |=> int_status[EV_FAILED]
  ) else $error("status bit dropped without a clear");

  a_pass_sets_status: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    pkt_end_in && check_ok_in |=> ##1 int_status[EV_PASSED]
  ) else $error("passed check did not set status");

  a_tone_sets_status: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    tone_present_in |=> ##1 int_status[EV_TONE]
  ) else $error("tone pulse did not set status");
endmodule

// ===== rxs_pkg.sv
package rxs_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_CHECK_VERDICT = 12'h400;
  localparam logic [11:0] OFS_LOGICAL_ADDR = 12'h408;
  localparam logic [11:0] OFS_CHECK_FIELD = 12'h40C;
  localparam logic [11:0] OFS_MATCH_INDEX = 12'h410;
  localparam logic [11:0] OFS_PAYLOAD_STATUS = 12'h414;
  localparam logic [11:0] OFS_TONE_INFO = 12'h44C;
  localparam logic [11:0] OFS_DF_STATE = 12'h458;
  localparam logic [11:0] OFS_INT_STATUS = 12'h600;
  localparam logic [11:0] OFS_INT_MASK = 12'h604;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  // ------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------
  localparam int LOG_ADDR_W = 3;
  localparam int CHECK_W_DEF = 24;
  localparam int MATCH_W = 3;
  localparam int PAYLOAD_W = 2;
  localparam int TONE_TIME_W = 5;
  localparam int TONE_TIME_LSB = 0;
  localparam int TONE_RSVD_BIT = 5;
  localparam int TONE_KIND_LSB = 6;
  localparam int TONE_KIND_W = 2;
  localparam int TONE_INFO_W = 8;
  localparam int SWITCH_W = 3;
  localparam int SAMPLER_BIT = 3;
  // Switching state codes
  localparam logic [2:0] SW_IDLE = 3'h0;
  localparam logic [2:0] SW_OFFSET = 3'h1;
  localparam logic [2:0] SW_GUARD = 3'h2;
  localparam logic [2:0] SW_REF = 3'h3;
  localparam logic [2:0] SW_SWITCHING = 3'h4;
  localparam logic [2:0] SW_ENDING = 3'h5;
  // ------------------------------------------------------------
  // Interrupt events
  // ------------------------------------------------------------
  localparam int EV_PASSED = 0;
  localparam int EV_FAILED = 1;
  localparam int EV_TONE = 2;
  localparam int NUM_EV = 3;
endpackage

// ===== rxs_cap_if.sv
`timescale 1ns/1ps
interface rxs_cap_if #(
  parameter int CHECK_W = 24
);
  import rxs_pkg::*;
  logic check_passed;
  logic [LOG_ADDR_W-1:0] log_addr;
  logic [CHECK_W-1:0] check_field;
  logic [MATCH_W-1:0] match_index;
  logic [PAYLOAD_W-1:0] payload;
  logic [TONE_TIME_W-1:0] tone_duration;
  logic tone_rsvd;
  logic [TONE_KIND_W-1:0] tone_kind;
  logic [NUM_EV-1:0] events;
  modport src (
    output check_passed, log_addr, check_field, match_index, payload,
    output tone_duration, tone_rsvd, tone_kind, events
  );
  modport dst (
    input check_passed, log_addr, check_field, match_index, payload,
    input tone_duration, tone_rsvd, tone_kind, events
  );
endinterface

// ===== rxs_capture.sv
`timescale 1ns/1ps
module rxs_capture
  import rxs_pkg::*;
#(
  parameter int CHECK_W = 24
)(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Radio results
  input wire logic pkt_end_in,
  input wire logic check_ok_in,
  input wire logic [LOG_ADDR_W-1:0] log_addr_in,
  input wire logic [CHECK_W-1:0] check_field_in,
  input wire logic [MATCH_W-1:0] match_index_in,
  input wire logic [PAYLOAD_W-1:0] payload_in,
  input wire logic tone_present_in,
  input wire logic [TONE_INFO_W-1:0] tone_info_in,
  // Captured fields
  rxs_cap_if.src cap
);
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      cap.check_passed <= 1'b0;
      cap.log_addr <= '0;
      cap.check_field <= '0;
      cap.match_index <= '0;
      cap.payload <= '0;
      cap.tone_duration <= '0;
      cap.tone_rsvd <= 1'b0;
      cap.tone_kind <= '0;
      cap.events <= '0;
    end
    else
    begin
      cap.events <= {tone_present_in, pkt_end_in & ~check_ok_in, pkt_end_in & check_ok_in};
      if (pkt_end_in)
      begin
        cap.check_passed <= check_ok_in;
        cap.log_addr <= log_addr_in;
        cap.check_field <= check_field_in;
        cap.match_index <= match_index_in;
        cap.payload <= payload_in;
      end
      if (tone_present_in)
      begin
        cap.tone_duration <= tone_info_in[TONE_TIME_LSB +: TONE_TIME_W];
        cap.tone_rsvd <= tone_info_in[TONE_RSVD_BIT];
        cap.tone_kind <= tone_info_in[TONE_KIND_LSB +: TONE_KIND_W];
      end
    end
  end
endmodule

// ===== rxs_irq.sv
`timescale 1ns/1ps
module rxs_irq
  import rxs_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Events and software access
  input wire logic [NUM_EV-1:0] events_in,
  input wire logic status_wr_in,
  input wire logic mask_wr_in,
  input wire logic [NUM_EV-1:0] wdata_in,
  // State
  output logic [NUM_EV-1:0] status_out,
  output logic [NUM_EV-1:0] mask_out,
  output logic irq_out
);
  logic [NUM_EV-1:0] status_next;
  logic [NUM_EV-1:0] clear_bits;
  assign clear_bits = status_wr_in ? wdata_in : '0;
  // Set wins over a write-one clear
  genvar i;
  generate
    for (i = 0; i < NUM_EV; i++)
    begin : g_bit
      assign status_next[i] = events_in[i] | (status_out[i] & ~clear_bits[i]);
    end
  endgenerate
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      status_out <= '0;
      mask_out <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      status_out <= status_next;
      if (mask_wr_in)
        mask_out <= wdata_in;
      irq_out <= |(status_next & (mask_wr_in ? wdata_in : mask_out));
    end
  end
endmodule

// ===== rxs_status_regs_tb.sv
`timescale 1ns/1ps
module rxs_status_regs_tb
  import rxs_pkg::*;
;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [ADDR_W-1:0] addr_in;
  logic [31:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [31:0] rdata_out;
  logic pkt_end_in;
  logic check_ok_in;
  logic [LOG_ADDR_W-1:0] log_addr_in;
  logic [CHECK_W_DEF-1:0] check_field_in;
  logic [MATCH_W-1:0] match_index_in;
  logic [PAYLOAD_W-1:0] payload_in;
  logic tone_present_in;
  logic [TONE_INFO_W-1:0] tone_info_in;
  logic [SWITCH_W-1:0] switch_state_in;
  logic sampler_state_in;
  logic irq_out;
  int miscompares = 0;
  int tests_run = 0;
  logic [11:0] ofs [10] = '{OFS_CHECK_VERDICT, OFS_LOGICAL_ADDR, OFS_CHECK_FIELD,
    OFS_MATCH_INDEX, OFS_PAYLOAD_STATUS, OFS_TONE_INFO, OFS_DF_STATE,
    OFS_INT_STATUS, OFS_INT_MASK, 12'h404};

  rxs_status_regs #(.CHECK_W(CHECK_W_DEF)) rxs_status_regs_inst (
    .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pkt_end_in(pkt_end_in),
    .check_ok_in(check_ok_in), .log_addr_in(log_addr_in),
    .check_field_in(check_field_in), .match_index_in(match_index_in),
    .payload_in(payload_in), .tone_present_in(tone_present_in),
    .tone_info_in(tone_info_in), .switch_state_in(switch_state_in),
    .sampler_state_in(sampler_state_in), .irq_out(irq_out)
  );

  always #20 clk_in = ~clk_in;

  // ------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check($sformatf("reg %h", a), d, exp);
  endtask

  task automatic pkt(input logic ok, input logic [2:0] la, input logic [23:0] cf,
                     input logic [2:0] mi, input logic [1:0] ps);
    @(posedge clk_in);
    check_ok_in <= ok;
    log_addr_in <= la;
    check_field_in <= cf;
    match_index_in <= mi;
    payload_in <= ps;
    pkt_end_in <= 1'b1;
    @(posedge clk_in);
    pkt_end_in <= 1'b0;
  endtask

  task automatic tone(input logic [7:0] t);
    @(posedge clk_in);
    tone_info_in <= t;
    tone_present_in <= 1'b1;
    @(posedge clk_in);
    tone_present_in <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial
  begin
    {addr_in, wdata_in, wr_in, rd_in, pkt_end_in, check_ok_in} = '0;
    {log_addr_in, check_field_in, match_index_in, payload_in} = '0;
    {tone_present_in, tone_info_in, switch_state_in, sampler_state_in} = '0;
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    foreach (ofs[i]) rd_chk(ofs[i], 32'h00000000);
    check("irq", {31'h0, irq_out}, 32'h00000000);
    // Passing packet, interrupt still masked
    pkt(1'b1, 3'h5, 24'hA5C3F1, 3'h6, 2'h3);
    rd_chk(OFS_INT_STATUS, 32'h00000001);
    check("irq", {31'h0, irq_out}, 32'h00000000);
    rd_chk(OFS_CHECK_VERDICT, 32'h00000001);
    @(posedge clk_in);
    #1 check("rdata", rdata_out, 32'h00000000);
    rd_chk(OFS_LOGICAL_ADDR, 32'h00000005);
    rd_chk(OFS_CHECK_FIELD, 32'h00A5C3F1);
    rd_chk(OFS_MATCH_INDEX, 32'h00000006);
    rd_chk(OFS_PAYLOAD_STATUS, 32'h00000003);
    // Writes to read-only places
    wr(OFS_CHECK_VERDICT, 32'hFFFFFFFF);
    wr(OFS_CHECK_FIELD, 32'h00000000);
    rd_chk(OFS_CHECK_VERDICT, 32'h00000001);
    rd_chk(OFS_CHECK_FIELD, 32'h00A5C3F1);
    // Unmask, then clear
    wr(OFS_INT_MASK, 32'hFFFFFFFF);
    rd_chk(OFS_INT_MASK, 32'h00000007);
    check("irq", {31'h0, irq_out}, 32'h00000001);
    wr(OFS_INT_STATUS, 32'h00000001);
    rd_chk(OFS_INT_STATUS, 32'h00000000);
    check("irq", {31'h0, irq_out}, 32'h00000000);
    // Failing packet with all-ones check field
    pkt(1'b0, 3'h2, 24'hFFFFFF, 3'h0, 2'h1);
    rd_chk(OFS_CHECK_VERDICT, 32'h00000000);
    rd_chk(OFS_LOGICAL_ADDR, 32'h00000002);
    rd_chk(OFS_CHECK_FIELD, 32'h00FFFFFF);
    rd_chk(OFS_MATCH_INDEX, 32'h00000000);
    rd_chk(OFS_PAYLOAD_STATUS, 32'h00000001);
    rd_chk(OFS_INT_STATUS, 32'h00000002);
    check("irq", {31'h0, irq_out}, 32'h00000001);
    wr(OFS_INT_STATUS, 32'h00000002);
    // Tone extension fields
    tone(8'hE5);
    rd_chk(OFS_TONE_INFO, 32'h000000E5);
    rd_chk(OFS_INT_STATUS, 32'h00000004);
    tone(8'h1A);
    rd_chk(OFS_TONE_INFO, 32'h0000001A);
    rd_chk(OFS_CHECK_VERDICT, 32'h00000000);
    // Tone event meets a clear of its own bit: set wins
    wr(OFS_INT_STATUS, 32'h00000004);
    rd_chk(OFS_INT_STATUS, 32'h00000000);
    tone(8'h47);
    addr_in <= OFS_INT_STATUS;
    wdata_in <= 32'h00000004;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_chk(OFS_INT_STATUS, 32'h00000004);
    check("irq", {31'h0, irq_out}, 32'h00000001);
    rd_chk(OFS_TONE_INFO, 32'h00000047);
    // Every machine state code
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 6; i++)
      begin
        @(posedge clk_in);
        switch_state_in <= 3'(i);
        sampler_state_in <= 1'(s);
        rd_chk(OFS_DF_STATE, {28'h0, 1'(s), 3'(i)});
      end
    wrap_up();
  end

  initial
  begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule
